/* File: rtl/sbs_pkg.sv */
// constants and types shared by the session sequencer
package sbs_pkg;
  localparam logic [7:0] CTL_CONNECT_REQUEST = 8'h01;
  localparam logic [7:0] CTL_CONNECT_REPLY = 8'h02;
  localparam logic [7:0] CTL_DISCONNECT_REQUEST = 8'h03;
  localparam logic [7:0] CTL_DISCONNECT_REPLY = 8'h04;
  localparam logic [7:0] CTL_DATA = 8'h05;
  localparam logic [7:0] CTL_ACK = 8'h06;
  localparam logic [7:0] CTL_ECHO_REQUEST = 8'h0B;
  localparam logic [7:0] CTL_LOOPBACK_REPLY = 8'h0C;
  localparam logic [7:0] SUB_GREETING = 8'h01;
  localparam logic [7:0] SUB_GREETING_REPLY = 8'h02;
  localparam logic [7:0] SUB_WRITE_DATA = 8'h05;
  localparam logic [3:0] SEQ_RESET = 4'h0;
  localparam logic [7:0] TID_RESET = 8'h00;
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_SEQUENCE = 4'h1;
  localparam logic [3:0] ERR_ALREADY_OPEN = 4'h2;
  localparam logic [3:0] ERR_NOT_OPEN = 4'h3;
  localparam logic [3:0] ERR_NOT_GREETED = 4'h4;
  localparam logic [3:0] ERR_BAD_CHANNEL = 4'h5;
  typedef enum logic [2:0] {
    SBS_CLOSED = 3'b000,
    SBS_WAIT_REPLY_ACK = 3'b001,
    SBS_CONNECTED = 3'b010,
    SBS_WAIT_GREET_ACK = 3'b011,
    SBS_OPEN = 3'b100,
    SBS_WAIT_DISC_ACK = 3'b101
  } sbs_state_e;
endpackage

/* File: rtl/sbs_advance_decode.sv */
// decides whether an acknowledged command advances counters
`timescale 1ns/1ps
module sbs_advance_decode (
  input wire logic [7:0] ctl,
  input wire logic [7:0] sub,
  input wire logic sig_ok,
  output logic adv_seq,
  output logic adv_tid
);
  always_comb begin
    adv_seq = 1'b0;
    adv_tid = 1'b0;
    case (ctl)
      sbs_pkg::CTL_DATA: begin
        adv_seq = 1'b1;
        // only write data steps the transaction id too, and only with sig_ok set
        adv_tid = (sub == sbs_pkg::SUB_WRITE_DATA) && sig_ok;
      end
      sbs_pkg::CTL_ECHO_REQUEST, sbs_pkg::CTL_LOOPBACK_REPLY: begin
        adv_seq = 1'b1;
      end
      default: begin
        adv_seq = 1'b0;
      end
    endcase
  end
endmodule

/* File: rtl/sbs_sequencer.sv */
// session sequencer for the secure boot loader link
// Summary of operation
// - device keeps own packet counter, advanced when acknowledgement of qualifying command completes.
// - only data transfer, greeting, greeting reply, echo and loopback acknowledgements advance.
// - unexpected packet counter value is a protocol error ending the session.
// - transaction id advances after signed, verified host-to-device write data, or after the host ack of device write data.
// - greeting exchange advances packet counter, leaves transaction id unchanged.
// - connect and disconnect commands, replies and acknowledgements never advance the counter; the disconnect reply ack resets it to zero.
// - host write data advances counter after its acknowledgement, and transaction id only when signed and verified.
// - connect request while session open raises an error.
// - opening runs request, ack, reply, ack with counter held at zero.
// - greeting at 0, reply at 1, final ack makes 2, session open.
// - control code 0x01 connect request, 0x02 connect reply.
// - control code 0x03 disconnect request, 0x04 disconnect reply.
// - control code 0x06 is the acknowledgement.
// - device write-data response advances both after host acknowledgement.
// - four-bit counter wraps modulo 16; acknowledgements are not new segments.
// - acknowledgement carries channel and counter of the acknowledged command.
`timescale 1ns/1ps
module sbs_sequencer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_ctl,
  input wire logic [7:0] rx_sub,
  input wire logic [3:0] rx_channel,
  input wire logic [3:0] rx_seq,
  input wire logic rx_sig_ok,
  input wire logic tx_valid,
  input wire logic [7:0] tx_ctl,
  input wire logic [7:0] tx_sub,
  output logic ack_valid,
  output logic [7:0] ack_ctl,
  output logic [3:0] ack_channel,
  output logic [3:0] ack_seq,
  output logic reply_valid,
  output logic [7:0] reply_ctl,
  output logic [3:0] packet_counter,
  output logic [7:0] transaction_id,
  output logic [3:0] channel_id,
  output logic session_open,
  output logic error_pulse,
  output logic [3:0] error_code
);
  sbs_pkg::sbs_state_e state_r, state_nxt;
  logic [3:0] seq_r, seq_nxt;
  logic [7:0] tid_r, tid_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic ack_valid_r, ack_valid_nxt;
  logic [7:0] ack_ctl_r, ack_ctl_nxt;
  logic [3:0] ack_chan_r, ack_chan_nxt;
  logic [3:0] ack_seq_r, ack_seq_nxt;
  logic rep_valid_r, rep_valid_nxt;
  logic [7:0] rep_ctl_r, rep_ctl_nxt;
  logic err_r, err_nxt;
  logic [3:0] code_r, code_nxt;
  // open flag registered on its own so the port comes straight from a flop
  logic open_r, open_nxt;
  // command awaiting the host acknowledgement of a device transmission
  logic [7:0] pend_ctl_r, pend_ctl_nxt;
  logic [7:0] pend_sub_r, pend_sub_nxt;
  logic [7:0] dec_ctl, dec_sub;
  logic dec_sig, adv_seq, adv_tid;

  sbs_advance_decode u_dec (
    .ctl(dec_ctl),
    .sub(dec_sub),
    .sig_ok(dec_sig),
    .adv_seq(adv_seq),
    .adv_tid(adv_tid)
  );

  // an incoming ack applies to our pending transmission, any other
  // command is decoded directly because we ack it in the same step
  always_comb begin
    if (rx_ctl == sbs_pkg::CTL_ACK) begin
      dec_ctl = pend_ctl_r;
      dec_sub = pend_sub_r;
      dec_sig = 1'b1; // acked write data steps the id without a signature check
    end else begin
      dec_ctl = rx_ctl;
      dec_sub = rx_sub;
      dec_sig = rx_sig_ok;
    end
  end

  function automatic logic is_data(input logic [7:0] c);
    is_data = (c == sbs_pkg::CTL_DATA) || (c == sbs_pkg::CTL_ECHO_REQUEST) ||
              (c == sbs_pkg::CTL_LOOPBACK_REPLY);
  endfunction

  always_comb begin
    state_nxt = state_r;
    seq_nxt = seq_r;
    tid_nxt = tid_r;
    chan_nxt = chan_r;
    ack_valid_nxt = 1'b0;
    ack_ctl_nxt = ack_ctl_r;
    ack_chan_nxt = ack_chan_r;
    ack_seq_nxt = ack_seq_r;
    rep_valid_nxt = 1'b0;
    rep_ctl_nxt = rep_ctl_r;
    err_nxt = 1'b0;
    code_nxt = code_r;
    pend_ctl_nxt = pend_ctl_r;
    pend_sub_nxt = pend_sub_r;
    if (tx_valid) begin
      // device-originated data segment waits for the host ack
      pend_ctl_nxt = tx_ctl;
      pend_sub_nxt = tx_sub;
    end
    if (rx_valid) begin
      case (state_r)
        sbs_pkg::SBS_CLOSED: begin
          if (rx_ctl == sbs_pkg::CTL_CONNECT_REQUEST && rx_seq == sbs_pkg::SEQ_RESET) begin
            chan_nxt = rx_channel;
            seq_nxt = sbs_pkg::SEQ_RESET;
            ack_valid_nxt = 1'b1;
            rep_valid_nxt = 1'b1;
            rep_ctl_nxt = sbs_pkg::CTL_CONNECT_REPLY;
            pend_ctl_nxt = sbs_pkg::CTL_CONNECT_REPLY;
            state_nxt = sbs_pkg::SBS_WAIT_REPLY_ACK;
          end else begin
            err_nxt = 1'b1;
            code_nxt = sbs_pkg::ERR_NOT_OPEN;
          end
        end
        default: begin
          if (rx_ctl == sbs_pkg::CTL_CONNECT_REQUEST) begin
            err_nxt = 1'b1;
            code_nxt = sbs_pkg::ERR_ALREADY_OPEN;
          end else if (rx_channel != chan_r || rx_seq != seq_r) begin
            // a mismatched segment is dropped with the session
            err_nxt = 1'b1;
            code_nxt = (rx_seq != seq_r) ? sbs_pkg::ERR_SEQUENCE : sbs_pkg::ERR_BAD_CHANNEL;
            state_nxt = sbs_pkg::SBS_CLOSED;
            seq_nxt = sbs_pkg::SEQ_RESET;
            tid_nxt = sbs_pkg::TID_RESET;
          end else if (rx_ctl == sbs_pkg::CTL_ACK) begin
            if (adv_seq) begin
              seq_nxt = 4'(seq_r + 4'h1);
            end
            if (adv_tid) begin
              tid_nxt = 8'(tid_r + 8'h01);
            end
            pend_ctl_nxt = 8'h00;
            case (state_r)
              sbs_pkg::SBS_WAIT_REPLY_ACK: state_nxt = sbs_pkg::SBS_CONNECTED;
              sbs_pkg::SBS_WAIT_GREET_ACK: state_nxt = sbs_pkg::SBS_OPEN;
              sbs_pkg::SBS_WAIT_DISC_ACK: begin
                state_nxt = sbs_pkg::SBS_CLOSED;
                seq_nxt = sbs_pkg::SEQ_RESET;
                tid_nxt = sbs_pkg::TID_RESET;
              end
              default: state_nxt = state_r;
            endcase
          end else if (rx_ctl == sbs_pkg::CTL_DISCONNECT_REQUEST) begin
            ack_valid_nxt = 1'b1;
            rep_valid_nxt = 1'b1;
            rep_ctl_nxt = sbs_pkg::CTL_DISCONNECT_REPLY;
            pend_ctl_nxt = sbs_pkg::CTL_DISCONNECT_REPLY;
            state_nxt = sbs_pkg::SBS_WAIT_DISC_ACK;
          end else if (state_r == sbs_pkg::SBS_CONNECTED && rx_ctl == sbs_pkg::CTL_DATA &&
                       rx_sub == sbs_pkg::SUB_GREETING) begin
            ack_valid_nxt = 1'b1;
            seq_nxt = 4'(seq_r + 4'h1);
            rep_valid_nxt = 1'b1;
            rep_ctl_nxt = sbs_pkg::CTL_DATA;
            pend_ctl_nxt = sbs_pkg::CTL_DATA;
            pend_sub_nxt = sbs_pkg::SUB_GREETING_REPLY;
            state_nxt = sbs_pkg::SBS_WAIT_GREET_ACK;
          end else if (state_r == sbs_pkg::SBS_OPEN && is_data(rx_ctl)) begin
            ack_valid_nxt = 1'b1;
            if (adv_seq) begin
              seq_nxt = 4'(seq_r + 4'h1);
            end
            if (adv_tid) begin
              tid_nxt = 8'(tid_r + 8'h01);
            end
          end else begin
            err_nxt = 1'b1;
            code_nxt = sbs_pkg::ERR_NOT_GREETED;
          end
          if (ack_valid_nxt) begin
            ack_ctl_nxt = sbs_pkg::CTL_ACK;
          end
        end
      endcase
      if (ack_valid_nxt) begin
        ack_ctl_nxt = sbs_pkg::CTL_ACK;
        ack_chan_nxt = rx_channel;
        ack_seq_nxt = rx_seq;
      end
    end
    open_nxt = (state_nxt == sbs_pkg::SBS_OPEN);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_r <= sbs_pkg::SBS_CLOSED;
      seq_r <= sbs_pkg::SEQ_RESET;
      tid_r <= sbs_pkg::TID_RESET;
      chan_r <= 4'h0;
      ack_valid_r <= 1'b0;
      ack_ctl_r <= sbs_pkg::CTL_ACK;
      ack_chan_r <= 4'h0;
      ack_seq_r <= 4'h0;
      rep_valid_r <= 1'b0;
      rep_ctl_r <= 8'h00;
      err_r <= 1'b0;
      code_r <= sbs_pkg::ERR_NONE;
      open_r <= 1'b0;
      pend_ctl_r <= 8'h00;
      pend_sub_r <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      seq_r <= seq_nxt;
      tid_r <= tid_nxt;
      chan_r <= chan_nxt;
      ack_valid_r <= ack_valid_nxt;
      ack_ctl_r <= ack_ctl_nxt;
      ack_chan_r <= ack_chan_nxt;
      ack_seq_r <= ack_seq_nxt;
      rep_valid_r <= rep_valid_nxt;
      rep_ctl_r <= rep_ctl_nxt;
      err_r <= err_nxt;
      code_r <= code_nxt;
      open_r <= open_nxt;
      pend_ctl_r <= pend_ctl_nxt;
      pend_sub_r <= pend_sub_nxt;
    end
  end

  assign ack_valid = ack_valid_r;
  assign ack_ctl = ack_ctl_r;
  assign ack_channel = ack_chan_r;
  assign ack_seq = ack_seq_r;
  assign reply_valid = rep_valid_r;
  assign reply_ctl = rep_ctl_r;
  assign packet_counter = seq_r;
  assign transaction_id = tid_r;
  assign channel_id = chan_r;
  assign session_open = open_r;
  assign error_pulse = err_r;
  assign error_code = code_r;
endmodule

/* File: test/sbs_host_model.sv */
// host-side model: frames bench requests and acknowledges device replies
`timescale 1ns/1ps
module sbs_host_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic req,
  input wire logic [7:0] q_ctl,
  input wire logic [7:0] q_sub,
  input wire logic [3:0] q_seq,
  input wire logic q_sig,
  input wire logic [3:0] hseq,
  input wire logic reply_valid,
  output logic rx_valid,
  output logic [7:0] rx_ctl,
  output logic [7:0] rx_sub,
  output logic [3:0] rx_channel,
  output logic [3:0] rx_seq,
  output logic rx_sig_ok
);
  always_ff @(posedge clock) begin
    rx_valid <= nrst && (req || reply_valid);
    rx_sig_ok <= req && q_sig;
    if (reply_valid) begin
      rx_ctl <= 8'h06;
      rx_seq <= hseq;
      rx_channel <= 4'h5;
    end else if (req) begin
      rx_ctl <= q_ctl;
      rx_sub <= q_sub;
      rx_seq <= (q_ctl == 8'h01) ? 4'h0 : q_seq;
      rx_channel <= 4'h5;
    end else begin
      // idle header toggles so a stale one never looks live
      rx_ctl <= nrst ? ~rx_ctl : 8'h00;
      rx_sub <= nrst ? ~rx_sub : 8'h00;
      rx_seq <= nrst ? ~rx_seq : 4'h0;
      rx_channel <= nrst ? ~rx_channel : 4'h0;
    end
  end
endmodule

/* File: test/sbs_checker.sv */
// port assertions for the session sequencer
`timescale 1ns/1ps
module sbs_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic rx_valid,
  input wire logic [7:0] rx_ctl,
  input wire logic [3:0] rx_channel,
  input wire logic [3:0] rx_seq,
  input wire logic ack_valid,
  input wire logic [7:0] ack_ctl,
  input wire logic [3:0] ack_channel,
  input wire logic [3:0] ack_seq,
  input wire logic reply_valid,
  input wire logic [7:0] reply_ctl,
  input wire logic [3:0] packet_counter,
  input wire logic [7:0] transaction_id,
  input wire logic [3:0] channel_id,
  input wire logic session_open,
  input wire logic error_pulse,
  input wire logic [3:0] error_code
);
  wire tk = rx_valid && clk_en;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence cmd_in;
    tk && rx_ctl != 8'h06;
  endsequence
  chk_cmd_answered: assert property (cmd_in |=> ack_valid || error_pulse) else $error("command unanswered");
  chk_ack_code: assert property (ack_valid |-> ack_ctl == 8'h06) else $error("ack code wrong");
  chk_ack_echo: assert property (cmd_in ##1 ack_valid |-> ack_seq == $past(rx_seq) &&
    ack_channel == $past(rx_channel)) else $error("ack header differs");
  chk_connect_reply: assert property (tk && rx_ctl == 8'h01 && !session_open |=>
    reply_valid && reply_ctl == 8'h02 && packet_counter == 4'h0) else $error("connect reply wrong");
  chk_reopen_error: assert property (tk && rx_ctl == 8'h01 && session_open |=>
    error_pulse && error_code == 4'h2 && session_open) else $error("reopen not flagged");
  chk_counter_step: assert property (packet_counter != $past(packet_counter) |->
    packet_counter == $past(packet_counter) + 4'h1 || packet_counter == 4'h0) else $error("counter jump");
  chk_disc_hold: assert property (tk && rx_ctl == 8'h03 && session_open && rx_seq == packet_counter &&
    rx_channel == channel_id |=> $stable(packet_counter) && reply_valid && reply_ctl == 8'h04)
    else $error("disconnect moved counter");
  chk_seq_error: assert property (tk && session_open && rx_ctl != 8'h01 && rx_channel == channel_id &&
    rx_seq != packet_counter |=> error_pulse && error_code == 4'h1 && !session_open &&
    packet_counter == 4'h0 && transaction_id == 8'h00) else $error("bad sequence kept");
endmodule
bind sbs_sequencer sbs_checker u_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en), .rx_valid(rx_valid),
  .rx_ctl(rx_ctl), .rx_channel(rx_channel), .rx_seq(rx_seq), .ack_valid(ack_valid), .ack_ctl(ack_ctl),
  .ack_channel(ack_channel), .ack_seq(ack_seq), .reply_valid(reply_valid), .reply_ctl(reply_ctl),
  .packet_counter(packet_counter), .transaction_id(transaction_id), .channel_id(channel_id),
  .session_open(session_open), .error_pulse(error_pulse), .error_code(error_code));

/* File: test/secure_boot_session_sequencer_test.sv */
// self-checking bench for the session sequencer
`timescale 1ns/1ps
module secure_boot_session_sequencer_test;
  logic clock = 1'b0, nrst = 1'b0, req = 1'b0, q_sig = 1'b0, tx_valid = 1'b0, clk_en = 1'b1;
  logic [7:0] q_ctl = 8'h00, q_sub = 8'h00, tx_ctl = 8'h00, tx_sub = 8'h00;
  logic [3:0] q_seq = 4'h0, hseq = 4'h0;
  logic rx_valid, rx_sig_ok, ack_valid, reply_valid, session_open, error_pulse;
  logic [7:0] rx_ctl, rx_sub, ack_ctl, reply_ctl, transaction_id;
  logic [3:0] rx_channel, rx_seq, ack_channel, ack_seq, packet_counter, channel_id, error_code;
  int mismatches = 0, checks_done = 0, cycles = 0;
  sbs_host_model host (.clock(clock), .nrst(nrst), .req(req), .q_ctl(q_ctl), .q_sub(q_sub), .q_seq(q_seq),
    .q_sig(q_sig), .hseq(hseq), .reply_valid(reply_valid), .rx_valid(rx_valid), .rx_ctl(rx_ctl),
    .rx_sub(rx_sub), .rx_channel(rx_channel), .rx_seq(rx_seq), .rx_sig_ok(rx_sig_ok));
  sbs_sequencer DUT (.clock(clock), .nrst(nrst), .clk_en(clk_en), .rx_valid(rx_valid), .rx_ctl(rx_ctl),
    .rx_sub(rx_sub), .rx_channel(rx_channel), .rx_seq(rx_seq), .rx_sig_ok(rx_sig_ok), .tx_valid(tx_valid),
    .tx_ctl(tx_ctl), .tx_sub(tx_sub), .ack_valid(ack_valid), .ack_ctl(ack_ctl), .ack_channel(ack_channel),
    .ack_seq(ack_seq), .reply_valid(reply_valid), .reply_ctl(reply_ctl), .packet_counter(packet_counter),
    .transaction_id(transaction_id), .channel_id(channel_id), .session_open(session_open),
    .error_pulse(error_pulse), .error_code(error_code));
  initial forever #25 clock = ~clock;
  task automatic summarize();
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // h is the host's counter copy used when it acks the device reply
  task automatic send(input logic [7:0] c, input logic [7:0] s, input logic [3:0] q, input logic g,
                      input logic [3:0] h);
    @(posedge clock);
    {req, q_ctl, q_sub, q_seq, q_sig, hseq} <= {1'b1, c, s, q, g, h};
    @(posedge clock);
    req <= 1'b0;
    repeat (5) @(posedge clock);
    #1;
  endtask
  task automatic state(input logic [3:0] pc, input logic [7:0] tid, input logic op);
    check("counter", 8'(packet_counter), 8'(pc));
    check("tid", transaction_id, tid);
    check("open", 8'(session_open), 8'(op));
  endtask
  task automatic t_closed();
    check("ack code", ack_ctl, 8'h06);
    send(8'h0B, 8'h00, 4'h0, 1'b0, 4'h0);
    check("err", 8'(error_code), 8'h03);
    state(4'h0, 8'h00, 1'b0);
  endtask
  task automatic t_open();
    send(8'h01, 8'h00, 4'h0, 1'b0, 4'h0);
    check("reply", reply_ctl, 8'h02);
    state(4'h0, 8'h00, 1'b0);
    send(8'h05, 8'h01, 4'h0, 1'b0, 4'h1);
    state(4'h2, 8'h00, 1'b1);
    check("ack seq", 8'(ack_seq), 8'h00);
    check("ack chan", 8'(ack_channel), 8'h05);
    check("chan", 8'(channel_id), 8'h05);
  endtask
  task automatic t_data();
    send(8'h05, 8'h05, 4'h2, 1'b1, 4'h2);
    state(4'h3, 8'h01, 1'b1);
    check("ack seq", 8'(ack_seq), 8'h02);
    send(8'h05, 8'h05, 4'h3, 1'b0, 4'h3);
    state(4'h4, 8'h01, 1'b1);
    @(posedge clock);
    {tx_valid, tx_ctl, tx_sub} <= {1'b1, 8'h05, 8'h05};
    @(posedge clock);
    tx_valid <= 1'b0;
    send(8'h06, 8'h00, 4'h4, 1'b0, 4'h4);
    state(4'h5, 8'h02, 1'b1);
  endtask
  task automatic t_wrap();
    for (int i = 5; i < 18; i++) begin
      send(8'h0B, 8'h00, 4'(i), 1'b0, 4'(i));
      check("counter", 8'(packet_counter), 8'((i + 1) % 16));
    end
  endtask
  // enable low: a bad-counter segment must be ignored, not end the session
  task automatic t_freeze();
    @(posedge clock);
    clk_en <= 1'b0;
    send(8'h0B, 8'h00, 4'h7, 1'b0, 4'h0);
    state(4'h2, 8'h02, 1'b1);
    @(posedge clock);
    clk_en <= 1'b1;
  endtask
  task automatic t_reopen_disc();
    send(8'h01, 8'h00, 4'h0, 1'b0, 4'h0);
    check("err", 8'(error_code), 8'h02);
    state(4'h2, 8'h02, 1'b1);
    send(8'h03, 8'h00, 4'h2, 1'b0, 4'h2);
    check("reply", reply_ctl, 8'h04);
    state(4'h0, 8'h00, 1'b0);
  endtask
  task automatic t_badseq();
    t_open();
    send(8'h0B, 8'h00, 4'h7, 1'b0, 4'h0);
    check("err", 8'(error_code), 8'h01);
    state(4'h0, 8'h00, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_closed();
    t_open();
    t_data();
    t_wrap();
    t_freeze();
    t_reopen_disc();
    t_badseq();
    summarize();
  end
  // generous ceiling: the whole run needs under two hundred cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      summarize();
    end
  end
endmodule
